// ==== src/bqsm_pkg.sv ====
package bqsm_pkg;

  // Stream shape
  localparam int SampleW = 24;
  localparam int NumCh = 8;
  localparam int NumSec = 12;
  localparam int NumCoef = 5;
  localparam int CoefW = 32;
  localparam int FifoDepth = 4;

  // Register index = page * PageSize + register; byte address = 4 * index
  localparam int PageSize = 128;
  localparam int IdxW = 10;
  localparam int AddrW = 12;
  localparam logic [2:0] PageCtl = 3'h0;
  localparam logic [2:0] PageBqLo = 3'h2;
  localparam logic [2:0] PageBqHi = 3'h3;
  localparam logic [2:0] PageMix = 3'h5;
  localparam logic [6:0] RegSumCfg = 7'h6B;
  localparam logic [6:0] RegBqCfg = 7'h6C;
  localparam logic [6:0] RegStatus = 7'h7E;
  localparam logic [6:0] RegCoefBase = 7'h08;
  localparam logic [6:0] RegMixLast = 7'h47;

  // Coefficient word store: biquad words first, then mixer words
  localparam int BqWords = NumSec * NumCoef;
  localparam int MixIn = 4;
  localparam int MixWords = MixIn * MixIn;
  localparam int NumWords = BqWords + MixWords;
  localparam logic [6:0] HiPageWordBase = 7'h1E;
  localparam logic [6:0] MixWordBase = 7'h3C;

  // Coefficient order inside one section block
  localparam int CoefNum0 = 0;
  localparam int CoefNum1 = 1;
  localparam int CoefNum2 = 2;
  localparam int CoefDen1 = 3;
  localparam int CoefDen2 = 4;

  // Control fields and reset values
  localparam int SumLsb = 2;
  localparam int BqCfgLsb = 5;
  localparam logic [7:0] SumCfgRst = 8'h00;
  localparam logic [7:0] BqCfgRst = 8'h40;
  localparam logic [1:0] SumNone = 2'h0;
  localparam logic [1:0] SumPair = 2'h1;
  localparam logic [1:0] SumQuad = 2'h2;
  localparam logic [1:0] BqOff = 2'h0;
  localparam logic [1:0] BqOne = 2'h1;
  localparam logic [1:0] BqTwo = 2'h2;
  localparam logic [1:0] BqThree = 2'h3;

  // Arithmetic
  localparam logic [31:0] Num0Rst = 32'h7FFFFFFF;
  localparam logic [31:0] MixUnity = 32'h40000000;
  localparam int BqFrac = 31;
  localparam int MixFrac = 30;
  localparam logic signed [63:0] BqRound = 64'sh0000000040000000;
  localparam logic signed [63:0] MixRound = 64'sh0000000020000000;

  // Bus answers
  localparam logic [1:0] RespOkay = 2'h0;
  localparam logic [1:0] RespSlvErr = 2'h2;

  typedef enum logic [3:0] {
    StIdle = 4'b0001,
    StFilt = 4'b0010,
    StMix  = 4'b0100,
    StOut  = 4'b1000
  } bqsm_state_t;

endpackage : bqsm_pkg

// ==== src/bqsm_top.sv ====
`timescale 1ns/1ps

module bqsm_fifo #(
  parameter int Width = 8,
  parameter int Depth = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [Width-1:0] outData
);
  localparam int PtrW = $clog2(Depth);
  localparam int CntW = $clog2(Depth + 1);

  logic [Width-1:0] mem_r [Depth];
  logic [PtrW-1:0] wrPtr_r;
  logic [PtrW-1:0] rdPtr_r;
  logic [CntW-1:0] count_r;
  logic [CntW-1:0] count_nxt;
  logic push;
  logic pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + CntW'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - CntW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= '0;
      inReady <= 1'b1;
    end else begin
      count_r <= count_nxt;
      inReady <= (count_nxt != CntW'(Depth));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == PtrW'(Depth - 1)) ? '0 : wrPtr_r + PtrW'(1);
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == PtrW'(Depth - 1)) ? '0 : rdPtr_r + PtrW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wrPtr_r] <= inData;
    end
  end
endmodule : bqsm_fifo

// Contract
// - Twelve second-order recursive sections are provided.
// - Section computes scaled biquad, unity two-to-31.
// - Reset coefficients pass samples unchanged.
// - Coefficients are 32-bit two's complement.
// - Allocation field bits 6:5; 00 disables.
// - Allocation 01: one section per channel.
// - Allocation 10 default: two sections, channels one-six.
// - Allocation 11: three sections, channels one-four.
// - Twenty byte registers per section, pages 2-3.
// - Summing field bits 3:2; 00 no summing.
// - Summing 01 averages channel pairs within channels one to six.
// - Summing 10 averages channels one to four.
// - Mixer active only when summing is 00.
// - Mixer scales inputs one-four, adds products.
// - Mixer k drives output channel k.
module bqsm_top #(
  parameter int SampleW = bqsm_pkg::SampleW,
  parameter int FifoDepth = bqsm_pkg::FifoDepth
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // AXI4-Lite register slave
  input wire logic [bqsm_pkg::AddrW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bqsm_pkg::AddrW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decimated frame in, channel 1 in the low bits
  input wire logic inValid,
  output logic inReady,
  input wire logic [bqsm_pkg::NumCh*SampleW-1:0] inSample,
  // Processed frame out
  output logic outValid,
  input wire logic outReady,
  output logic [bqsm_pkg::NumCh*SampleW-1:0] outSample
);
  localparam int NumCh = bqsm_pkg::NumCh;
  localparam int NumSec = bqsm_pkg::NumSec;
  localparam int NumWords = bqsm_pkg::NumWords;
  localparam int FrameW = NumCh * SampleW;

  // Coefficient byte decode: {hit, word[6:0], lane[1:0]}
  function automatic logic [9:0] coefSel(input logic [bqsm_pkg::IdxW-1:0] idx);
    logic [2:0] page;
    logic [6:0] reg_;
    logic [6:0] off;
    page = idx[9:7];
    reg_ = idx[6:0];
    off = reg_ - bqsm_pkg::RegCoefBase;
    coefSel = '0;
    if ((page == bqsm_pkg::PageBqLo) && (reg_ >= bqsm_pkg::RegCoefBase)) begin
      coefSel = {1'b1, {2'b00, off[6:2]}, ~off[1:0]};
    end else if ((page == bqsm_pkg::PageBqHi) && (reg_ >= bqsm_pkg::RegCoefBase)) begin
      coefSel = {1'b1, bqsm_pkg::HiPageWordBase + {2'b00, off[6:2]}, ~off[1:0]};
    end else if ((page == bqsm_pkg::PageMix) && (reg_ >= bqsm_pkg::RegCoefBase)
                 && (reg_ <= bqsm_pkg::RegMixLast)) begin
      coefSel = {1'b1, bqsm_pkg::MixWordBase + {2'b00, off[6:2]}, ~off[1:0]};
    end
  endfunction : coefSel

  // Section to channel: {used, channel index from 0}
  function automatic logic [3:0] secChan(input logic [1:0] cfg, input logic [3:0] sec);
    secChan = '0;
    case (cfg)
      bqsm_pkg::BqOne: begin
        if (sec < 4'h4) begin
          secChan = {1'b1, sec[2:0]};
        end else if (sec >= 4'h8) begin
          secChan = {1'b1, 3'(sec - 4'h4)};
        end
      end
      bqsm_pkg::BqTwo: begin
        if (sec < 4'h8) begin
          secChan = {2'b10, sec[1:0]};
        end else begin
          secChan = {3'b110, sec[0]};
        end
      end
      bqsm_pkg::BqThree: begin
        secChan = {2'b10, sec[1:0]};
      end
      default: begin
        secChan = '0;
      end
    endcase
  endfunction : secChan

  function automatic logic signed [63:0] mulExt(input logic signed [31:0] c,
                                                input logic signed [SampleW-1:0] s);
    mulExt = 64'(c) * 64'(s);
  endfunction : mulExt

  function automatic logic signed [SampleW-1:0] sat(input logic signed [63:0] v);
    logic signed [63:0] hi;
    logic signed [63:0] lo;
    hi = (64'sd1 <<< (SampleW - 1)) - 64'sd1;
    lo = -(64'sd1 <<< (SampleW - 1));
    if (v > hi) begin
      sat = SampleW'(hi);
    end else if (v < lo) begin
      sat = SampleW'(lo);
    end else begin
      sat = SampleW'(v);
    end
  endfunction : sat

  // Registers
  logic [31:0] coef_r [NumWords];
  logic [7:0] sumCfg_r;
  logic [7:0] bqCfg_r;
  logic [1:0] sumMode;
  logic [1:0] bqMode;

  // Bus slave state
  logic awHeld_r;
  logic wHeld_r;
  logic [bqsm_pkg::AddrW-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite;
  logic [9:0] wSel;
  logic [9:0] rSel;
  logic [bqsm_pkg::IdxW-1:0] wIdx;
  logic [bqsm_pkg::IdxW-1:0] rIdx;
  logic wCtlHit;
  logic [31:0] rdMux;
  logic rdErr;

  // Datapath state
  bqsm_pkg::bqsm_state_t state_r;
  logic [3:0] secIdx_r;
  logic signed [SampleW-1:0] work_r [NumCh];
  logic signed [SampleW-1:0] x1_r [NumSec];
  logic signed [SampleW-1:0] x2_r [NumSec];
  logic signed [SampleW-1:0] y1_r [NumSec];
  logic signed [SampleW-1:0] y2_r [NumSec];
  logic fifoValid;
  logic fifoReady;
  logic [FrameW-1:0] fifoData;
  logic [3:0] mapNow;
  logic [2:0] chNow;
  logic [6:0] cBase;
  logic signed [SampleW-1:0] xNow;
  logic signed [SampleW-1:0] yNow;
  logic signed [63:0] bqAcc;
  logic [FrameW-1:0] frameOut;

  assign sumMode = sumCfg_r[bqsm_pkg::SumLsb +: 2];
  assign bqMode = bqCfg_r[bqsm_pkg::BqCfgLsb +: 2];

  // Write channel: address and data taken in either order
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wIdx = awAddr_r[bqsm_pkg::AddrW-1:2];
  assign wSel = coefSel(wIdx);
  assign wCtlHit = (wIdx[9:7] == bqsm_pkg::PageCtl)
                   && ((wIdx[6:0] == bqsm_pkg::RegSumCfg)
                       || (wIdx[6:0] == bqsm_pkg::RegBqCfg)
                       || (wIdx[6:0] == bqsm_pkg::RegStatus));

  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bqsm_pkg::RespOkay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wSel[9] || wCtlHit) ? bqsm_pkg::RespOkay : bqsm_pkg::RespSlvErr;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control registers; status is read-only
  always_ff @(posedge clk) begin
    if (srst) begin
      sumCfg_r <= bqsm_pkg::SumCfgRst;
      bqCfg_r <= bqsm_pkg::BqCfgRst;
    end else if (doWrite && wStrb_r[0] && (wIdx[9:7] == bqsm_pkg::PageCtl)) begin
      if (wIdx[6:0] == bqsm_pkg::RegSumCfg) begin
        sumCfg_r <= wData_r[7:0];
      end else if (wIdx[6:0] == bqsm_pkg::RegBqCfg) begin
        bqCfg_r <= wData_r[7:0];
      end
    end
  end

  // Coefficient bytes, first register of each word is its top byte
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int w = 0; w < NumWords; w++) begin
        if (w < bqsm_pkg::BqWords) begin
          coef_r[w] <= ((w % bqsm_pkg::NumCoef) == bqsm_pkg::CoefNum0) ?
                       bqsm_pkg::Num0Rst : 32'h00000000;
        end else begin
          coef_r[w] <= (((w - bqsm_pkg::BqWords) % (bqsm_pkg::MixIn + 1)) == 0) ?
                       bqsm_pkg::MixUnity : 32'h00000000;
        end
      end
    end else if (doWrite && wStrb_r[0] && wSel[9]) begin
      coef_r[wSel[8:2]][{wSel[1:0], 3'b000} +: 8] <= wData_r[7:0];
    end
  end

  // Read channel: answer one cycle after the address is taken
  assign rIdx = s_axi_araddr[bqsm_pkg::AddrW-1:2];
  assign rSel = coefSel(rIdx);

  always_comb begin
    rdMux = 32'h00000000;
    rdErr = 1'b0;
    if (rSel[9]) begin
      rdMux = {24'h000000, coef_r[rSel[8:2]][{rSel[1:0], 3'b000} +: 8]};
    end else if ((rIdx[9:7] == bqsm_pkg::PageCtl) && (rIdx[6:0] == bqsm_pkg::RegSumCfg)) begin
      rdMux = {24'h000000, sumCfg_r};
    end else if ((rIdx[9:7] == bqsm_pkg::PageCtl) && (rIdx[6:0] == bqsm_pkg::RegBqCfg)) begin
      rdMux = {24'h000000, bqCfg_r};
    end else if ((rIdx[9:7] == bqsm_pkg::PageCtl) && (rIdx[6:0] == bqsm_pkg::RegStatus)) begin
      rdMux = {20'h00000, secIdx_r, 4'(state_r), 3'h0, fifoValid};
    end else begin
      rdErr = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= bqsm_pkg::RespOkay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdErr ? bqsm_pkg::RespSlvErr : bqsm_pkg::RespOkay;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  bqsm_fifo #(
    .Width(FrameW),
    .Depth(FifoDepth)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .inValid(inValid),
    .inReady(inReady),
    .inData(inSample),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
  );

  assign fifoReady = (state_r == bqsm_pkg::StIdle);

  // Sequencer: one section per cycle, ascending, then mix, then hand out
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= bqsm_pkg::StIdle;
      secIdx_r <= 4'h0;
    end else begin
      case (state_r)
        bqsm_pkg::StIdle: begin
          if (fifoValid) begin
            state_r <= bqsm_pkg::StFilt;
            secIdx_r <= 4'h0;
          end
        end
        bqsm_pkg::StFilt: begin
          secIdx_r <= secIdx_r + 4'h1;
          if (secIdx_r == 4'(NumSec - 1)) begin
            state_r <= bqsm_pkg::StMix;
          end
        end
        bqsm_pkg::StMix: begin
          state_r <= bqsm_pkg::StOut;
        end
        bqsm_pkg::StOut: begin
          if (outReady) begin
            state_r <= bqsm_pkg::StIdle;
          end
        end
        default: begin
          state_r <= bqsm_pkg::StIdle;
        end
      endcase
    end
  end

  // One biquad step on the channel that owns the current section
  assign mapNow = secChan(bqMode, secIdx_r);
  assign chNow = mapNow[2:0];
  assign cBase = 7'(secIdx_r) * 7'(bqsm_pkg::NumCoef);
  assign xNow = work_r[chNow];
  assign bqAcc = mulExt(coef_r[cBase + 7'(bqsm_pkg::CoefNum0)], xNow)
               + (mulExt(coef_r[cBase + 7'(bqsm_pkg::CoefNum1)], x1_r[secIdx_r]) <<< 1)
               + mulExt(coef_r[cBase + 7'(bqsm_pkg::CoefNum2)], x2_r[secIdx_r])
               + (mulExt(coef_r[cBase + 7'(bqsm_pkg::CoefDen1)], y1_r[secIdx_r]) <<< 1)
               + mulExt(coef_r[cBase + 7'(bqsm_pkg::CoefDen2)], y2_r[secIdx_r])
               + bqsm_pkg::BqRound;
  assign yNow = sat(bqAcc >>> bqsm_pkg::BqFrac);

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int c = 0; c < NumCh; c++) begin
        work_r[c] <= '0;
      end
    end else if ((state_r == bqsm_pkg::StIdle) && fifoValid) begin
      for (int c = 0; c < NumCh; c++) begin
        work_r[c] <= fifoData[c*SampleW +: SampleW];
      end
    end else if ((state_r == bqsm_pkg::StFilt) && mapNow[3]) begin
      work_r[chNow] <= yNow;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int s = 0; s < NumSec; s++) begin
        x1_r[s] <= '0;
        x2_r[s] <= '0;
        y1_r[s] <= '0;
        y2_r[s] <= '0;
      end
    end else if ((state_r == bqsm_pkg::StFilt) && mapNow[3]) begin
      x1_r[secIdx_r] <= xNow;
      x2_r[secIdx_r] <= x1_r[secIdx_r];
      y1_r[secIdx_r] <= yNow;
      y2_r[secIdx_r] <= y1_r[secIdx_r];
    end
  end

  // Summing or mixing on the filtered frame
  always_comb begin
    logic signed [63:0] acc;
    acc = '0;
    frameOut = '0;
    for (int c = 0; c < NumCh; c++) begin
      frameOut[c*SampleW +: SampleW] = work_r[c];
    end
    if (sumMode == bqsm_pkg::SumPair) begin
      for (int p = 0; p < 3; p++) begin
        acc = 64'(work_r[2*p]) + 64'(work_r[2*p+1]);
        frameOut[2*p*SampleW +: SampleW] = sat(acc >>> 1);
        frameOut[(2*p+1)*SampleW +: SampleW] = sat(acc >>> 1);
      end
    end else if (sumMode == bqsm_pkg::SumQuad) begin
      acc = 64'(work_r[0]) + 64'(work_r[1]) + 64'(work_r[2]) + 64'(work_r[3]);
      for (int c = 0; c < bqsm_pkg::MixIn; c++) begin
        frameOut[c*SampleW +: SampleW] = sat(acc >>> 2);
      end
    end else if (sumMode == bqsm_pkg::SumNone) begin
      for (int k = 0; k < bqsm_pkg::MixIn; k++) begin
        acc = bqsm_pkg::MixRound;
        for (int j = 0; j < bqsm_pkg::MixIn; j++) begin
          acc = acc + mulExt(coef_r[bqsm_pkg::BqWords + k*bqsm_pkg::MixIn + j],
                             work_r[j]);
        end
        frameOut[k*SampleW +: SampleW] = sat(acc >>> bqsm_pkg::MixFrac);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      outValid <= 1'b0;
      outSample <= '0;
    end else if (state_r == bqsm_pkg::StMix) begin
      outValid <= 1'b1;
      outSample <= frameOut;
    end else if ((state_r == bqsm_pkg::StOut) && outReady) begin
      outValid <= 1'b0;
    end
  end
endmodule : bqsm_top

// ==== testbench/bqsm_top_assertions.sv ====
`timescale 1ns/1ps
module bqsm_top_checker #(
  parameter int SampleW = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bqsm_pkg::AddrW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Stream
  input wire logic inValid,
  input wire logic inReady,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [bqsm_pkg::NumCh*SampleW-1:0] outSample
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_aw_busy;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("second write taken");
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write answer late");
  property p_r_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_time: assert property (p_r_time) else $error("read answer late");
  // Page 2 registers 0 to 7 hold no coefficient
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:5] == 7'h20
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not refused");
  property p_out_hold;
    outValid && !outReady |=> outValid && $stable(outSample);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("frame dropped");
  // Twelve sections in turn leave a gap between frames
  property p_out_gap;
    outValid && outReady |=> !outValid [*8];
  endproperty
  a_out_gap: assert property (p_out_gap) else $error("frames too close");

  c_out: cover property (outValid && outReady);
  c_full: cover property (inValid && !inReady);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : bqsm_top_checker

bind bqsm_top bqsm_top_checker #(.SampleW(SampleW)) bqsm_top_checker_i (.clk, .srst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .inValid, .inReady,
  .outValid, .outReady, .outSample);

// ==== testbench/bqsm_stream_model.sv ====
`timescale 1ns/1ps
module bqsm_stream_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Sink stall
  input wire logic slow,
  // Frame source
  output logic inValid = 1'b0,
  input wire logic inReady,
  output logic [bqsm_pkg::NumCh*bqsm_pkg::SampleW-1:0] inSample = '0,
  // Frame sink
  input wire logic outValid,
  output logic outReady = 1'b1,
  input wire logic [bqsm_pkg::NumCh*bqsm_pkg::SampleW-1:0] outSample
);
  logic [1:0] phase = 2'h0;
  logic [bqsm_pkg::NumCh*bqsm_pkg::SampleW-1:0] got[$];
  int refused = 0;
  int toErr = 0;

  // Slow sink takes a frame every fourth cycle
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    outReady <= !slow || phase == 2'h3;
    if (!srst && outValid && outReady) got.push_back(outSample);
    if (!srst && inValid && !inReady) refused <= refused + 1;
  end

  task automatic push(input logic [bqsm_pkg::NumCh*bqsm_pkg::SampleW-1:0] f);
    int n;
    @(posedge clk);
    inValid <= 1'b1;
    inSample <= f;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (inReady) break;
    end
    if (n == 400) toErr++;
    inValid <= 1'b0;
    // Released data lines show no stale frame
    inSample <= ~f;
  endtask : push
endmodule : bqsm_stream_model

// ==== testbench/bqsm_top_test.sv ====
`timescale 1ns/1ps
module bqsm_top_test;
  localparam int FrameW = bqsm_pkg::NumCh * bqsm_pkg::SampleW;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic slow = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic inValid, inReady, outValid, outReady;
  logic [FrameW-1:0] inSample, outSample;
  int n_fail = 0;
  int compares = 0;
  int vi[8];
  int ve[8];
  int am[4] = '{1, 2, 3, 0};
  int tg[4] = '{4, 4, 0, -1};

  bqsm_top bqsm_top_i (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .inValid, .inReady, .inSample,
    .outValid, .outReady, .outSample);
  bqsm_stream_model bqsm_stream_model_i (.clk, .srst, .slow, .inValid, .inReady,
    .inSample, .outValid, .outReady, .outSample);

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [FrameW-1:0] seen,
                     input logic [FrameW-1:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic guard(input bit hit);
    if (hit) begin
      chk("wait", 1, 0);
      final_report();
    end
  endtask : guard

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    guard(n == 50);
    chk("bresp", FrameW'(s_axi_bresp), FrameW'(er));
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    guard(n == 50);
    chk("rdata", FrameW'(s_axi_rdata), FrameW'(d));
    chk("rresp", FrameW'(s_axi_rresp), FrameW'(er));
  endtask : rd

  function automatic logic [FrameW-1:0] pk(input bit e);
    for (int k = 0; k < 8; k++) pk[24*k +: 24] = e ? ve[k][23:0] : vi[k][23:0];
  endfunction : pk

  // Expected frame: halving section on one channel, then summing or mixing
  task automatic mkexp(input logic [1:0] sm, input bit mix, input int tgt);
    ve = vi;
    if (tgt >= 0) ve[tgt] = (vi[tgt] + 1) >>> 1;
    if (sm == 2'h1) for (int k = 0; k < 6; k++) ve[k] = (vi[k & 6] + vi[k | 1]) >>> 1;
    if (sm == 2'h2) for (int k = 0; k < 4; k++) ve[k] = (vi[0] + vi[1] + vi[2] + vi[3]) >>> 2;
    if (sm == 2'h0 && mix) ve[0] = (vi[0] + vi[1] > 8388607) ? 8388607 : vi[0] + vi[1];
  endtask : mkexp

  task automatic run(input string nm);
    int n;
    bqsm_stream_model_i.push(pk(1'b0));
    for (n = 0; n < 100 && bqsm_stream_model_i.got.size() == 0; n++) @(posedge clk);
    guard(n == 100);
    chk(nm, bqsm_stream_model_i.got.pop_front(), pk(1'b1));
  endtask : run

  initial begin
    int n;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    vi = '{-7, -4, -1, 2, 5, 8, 11, 8388607};
    rd(12'h1B0, 8'h40, 2'h0);
    rd(12'h1AC, 8'h00, 2'h0);
    rd(12'h420, 8'h7F, 2'h0);
    rd(12'h42C, 8'hFF, 2'h0);
    rd(12'h400, 8'h00, 2'h2);
    wr(12'h41C, 8'h11, 2'h2);
    mkexp(2'h0, 1'b0, -1);
    run("pass");
    // Section 9 gain one half, loaded before streaming
    for (int k = 0; k < 4; k++) wr(12'h6C0 + 12'(4 * k), k == 0 ? 8'h40 : 8'h00, 2'h0);
    for (int m = 0; m < 4; m++) begin
      wr(12'h1B0, 8'(am[m] << 5), 2'h0);
      mkexp(2'h0, 1'b0, tg[m]);
      run("alloc");
    end
    // Mixer 1 takes input 2 at unity as well
    for (int k = 0; k < 4; k++) wr(12'hA30 + 12'(4 * k), k == 0 ? 8'h40 : 8'h00, 2'h0);
    mkexp(2'h0, 1'b1, -1);
    run("mix");
    wr(12'h1AC, 8'h04, 2'h0);
    mkexp(2'h1, 1'b1, -1);
    run("pair");
    wr(12'h1AC, 8'h08, 2'h0);
    mkexp(2'h2, 1'b1, -1);
    run("quad");
    rd(12'h1AC, 8'h08, 2'h0);
    wr(12'h1AC, 8'h00, 2'h0);
    slow <= 1'b1;
    // Full-scale second input drives mixer 1 into saturation
    vi[1] = 8388607;
    for (int i = 0; i < 6; i++) begin
      vi[0] = 10 * i;
      bqsm_stream_model_i.push(pk(1'b0));
    end
    for (n = 0; n < 400 && bqsm_stream_model_i.got.size() < 6; n++) @(posedge clk);
    guard(n == 400);
    for (int i = 0; i < 6; i++) begin
      vi[0] = 10 * i;
      mkexp(2'h0, 1'b1, -1);
      chk("queued", bqsm_stream_model_i.got.pop_front(), pk(1'b1));
    end
    chk("refused", FrameW'(bqsm_stream_model_i.refused != 0), 1);
    chk("push", FrameW'(bqsm_stream_model_i.toErr), 0);
    final_report();
  end
endmodule : bqsm_top_test
